// ---- inc/tso_pkg.sv ----
// Package: constants and types for the test/signal output control block
// ****************************************************************
// Notes on behaviour
// - No error while monitoring off, however long discrepant
// - Pair result stays inactive until both inactive
// - Two configurable outputs per input connector
// - Six modes: on, off, remote, lamp, test, gap
// - Lamp mode only on connector one output A
// - Gap 10..1270 ms, 5 ms steps, above delay
// - Delay setting 0..1265 ms in 5 ms steps
// - Period 15..1275 ms, 5 ms steps, above gap
// - Fixed modes ignore controller data, no error
// - Lamp error on undercurrent, lamp off, stuck high
// - Lamp status one only in lamp mode with current
// - Lamp status zero on error, forced off, other mode
// ****************************************************************
package tso_pkg;

   // ****************************************************************
   // Register map (APB byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_MODE   = 8'h00;
   localparam logic [7:0] ADDR_OUTBIT = 8'h04;
   localparam logic [7:0] ADDR_GAP    = 8'h08;
   localparam logic [7:0] ADDR_PERIOD = 8'h0c;
   localparam logic [7:0] ADDR_PAIR   = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQST  = 8'h18;
   localparam logic [7:0] ADDR_IRQMSK = 8'h1c;

   // ****************************************************************
   // Counts and reset values
   // ****************************************************************
   localparam int unsigned CLK_HZ      = 100_000_000;
   localparam int unsigned STEP_MS     = 5;
   localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
   localparam logic [7:0]  GAP_MIN     = 8'h02;   // 10 ms in 5 ms steps
   localparam logic [7:0]  GAP_RST     = 8'h02;
   localparam logic [7:0]  DELAY_RST   = 8'h00;
   localparam logic [7:0]  PERIOD_RST  = 8'hff;
   localparam logic [2:0]  MODE_RST    = 3'h1;

   // Interrupt status bit positions
   localparam int unsigned IRQ_LAMP    = 0;
   localparam int unsigned IRQ_CFG     = 1;
   localparam int unsigned IRQ_W       = 2;

   // Output modes
   typedef enum logic [2:0] {
      MODE_ON     = 3'h0,
      MODE_OFF    = 3'h1,
      MODE_REMOTE = 3'h2,
      MODE_LAMP   = 3'h3,
      MODE_TEST   = 3'h4,
      MODE_GAP    = 3'h5
   } out_mode_t;

   // Long-gap timing setting, all in 5 ms steps
   typedef struct packed {
      logic [7:0] gap;
      logic [7:0] delay;
   } gap_cfg_t;

   // Dual-channel pair evaluation states
   typedef enum logic [1:0] {
      PAIR_IDLE  = 2'b01,
      PAIR_ARMED = 2'b10
   } pair_state_t;

endpackage

// ---- design/pair_eval.sv ----
// Dual-channel evaluation without discrepancy time monitoring
`timescale 1ns/10ps
module pair_eval
   import tso_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Channel inputs, active high
   input  wire logic chanA,
   input  wire logic chanB,
   // Evaluated result
   output logic      pairActive
);

   pair_state_t stateQ, stateD;
   logic        actQ, actD;

   // Result only rises after both channels were seen inactive together;
   // a lone discrepant channel never raises an error here
   always_comb begin
      stateD = stateQ;
      actD   = 1'b0;
      case (stateQ)
         PAIR_IDLE: begin
            if (!chanA && !chanB) begin
               stateD = PAIR_ARMED;
            end
         end
         PAIR_ARMED: begin
            if (chanA && chanB) begin
               actD = 1'b1;
            end else if (chanA || chanB) begin
               if (actQ) begin
                  stateD = PAIR_IDLE; // Must go fully inactive again
               end
            end
         end
         default: stateD = PAIR_IDLE;
      endcase
   end

   // Register the state
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stateQ <= PAIR_IDLE;
         actQ   <= 1'b0;
      end else begin
         stateQ <= stateD;
         actQ   <= actD;
      end
   end

   assign pairActive = actQ;

endmodule

// ---- design/test_signal_output_control.sv ----
// Test/signal output control with lamp monitoring and APB registers
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
module test_signal_output_control
   import tso_pkg::*;
#(
   parameter int unsigned NUM_CONN    = 4,
   parameter int unsigned STEP_CYC    = STEP_CYCLES
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Standard test pulse source and safe-state force
   input  wire logic                  testPulse,
   input  wire logic                  forceInactive,
   // Lamp current monitor on connector one output A
   input  wire logic                  lampCurrentOk,
   input  wire logic                  lampStuckHigh,
   // Dual-channel pair inputs, one pair per connector
   input  wire logic [NUM_CONN-1:0]   pairChanA,
   input  wire logic [NUM_CONN-1:0]   pairChanB,
   // Outputs
   output logic [2*NUM_CONN-1:0]      test_signal_output,
   output logic [NUM_CONN-1:0]        pairResult,
   output logic                       lampStatus,
   output logic                       irq
);

   // Two outputs per connector
   localparam int unsigned NOUT = 2 * NUM_CONN;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Lamp mode is legal only on output 0, connector one output A
   function automatic logic modeLegal(input logic [2:0] m, input int idx);
      logic ok;
      ok = (m <= MODE_GAP);
      if (m == MODE_LAMP && idx != 0) begin
         ok = 1'b0;
      end
      return ok;
   endfunction

   function automatic logic isAddr(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   // Mode field of one output within a register word; 3 bits on a
   // 4-bit stride, so the top bit of every nibble is ignored
   function automatic logic [2:0] modeField(input logic [31:0] w,
                                            input int idx);
      return w[4*idx +: 3];
   endfunction

   // Next step of the long-gap period; counted in 9 bits so the wrap
   // test cannot overflow at the top of the range
   function automatic logic [7:0] nextStep(input logic [7:0] s,
                                           input logic [7:0] p);
      logic [8:0] inc;
      inc = {1'b0, s} + 9'h1;
      return (inc >= {1'b0, p}) ? 8'h0 : inc[7:0];
   endfunction

   // ****************************************************************
   // Register state
   // ****************************************************************
   // One mode per output, kept in a small array
   logic [2:0]      modeQ [NOUT];
   logic [2:0]      modeD [NOUT];
   logic [NOUT-1:0] outBitQ, outBitD;
   gap_cfg_t        gapCfgQ, gapCfgD;
   logic [7:0]      periodQ, periodD;
   logic [IRQ_W-1:0] irqStQ, irqStD, irqMskQ, irqMskD;
   logic [31:0]     rdataQ, rdataD;
   logic            readyQ, readyD, errQ, errD;
   logic            cfgBad;
   logic            lampErr;

   // An access is taken once; the registered ready blocks a second
   // take while the master still holds psel and penable high
   wire logic access = psel && penable && !readyQ;
   wire logic wrEn   = access && pwrite;

   // Lamp error: undercurrent/lamp off or output stuck high
   // Reads the registered output, so there is no loop through outD
   assign lampErr = (modeQ[0] == MODE_LAMP) &&
                    ((test_signal_output[0] && !lampCurrentOk) ||
                     (!test_signal_output[0] && lampStuckHigh));

   // Next register values; one wait state then pready
   // A write lands at the first access edge; pready rises at that same edge
   always_comb begin
      for (int i = 0; i < NOUT; i++) begin
         modeD[i] = modeQ[i];
      end
      outBitD = outBitQ;
      gapCfgD = gapCfgQ;
      periodD = periodQ;
      irqMskD = irqMskQ;
      irqStD  = irqStQ;
      rdataD  = 32'h0;
      readyD  = access;
      errD    = 1'b0;
      cfgBad  = 1'b0;
      if (wrEn) begin
         if (isAddr(paddr, ADDR_MODE)) begin
            for (int i = 0; i < NOUT; i++) begin
               if (modeLegal(modeField(pwdata, i), i)) begin
                  modeD[i] = modeField(pwdata, i);
               end else begin
                  cfgBad = 1'b1;
               end
            end
         end else if (isAddr(paddr, ADDR_OUTBIT)) begin
            outBitD = pwdata[NOUT-1:0];
         end else if (isAddr(paddr, ADDR_GAP)) begin
            // Gap at least 10 ms and above delay
            if (pwdata[7:0] < GAP_MIN || pwdata[7:0] <= pwdata[15:8]) begin
               cfgBad = 1'b1;
            end else if (pwdata[7:0] >= periodQ) begin
               // A gap as long as the period would never go active
               cfgBad = 1'b1;
            end else begin
               gapCfgD = '{gap: pwdata[7:0], delay: pwdata[15:8]};
            end
         end else if (isAddr(paddr, ADDR_PERIOD)) begin
            // Period must stay longer than the gap, else it is kept
            if (pwdata[7:0] > gapCfgQ.gap) begin
               periodD = pwdata[7:0];
            end else begin
               cfgBad = 1'b1;
            end
         end else if (isAddr(paddr, ADDR_IRQST)) begin
            // Write one to clear; a set in the same cycle wins below
            irqStD = irqStQ & ~pwdata[IRQ_W-1:0];
         end else if (isAddr(paddr, ADDR_IRQMSK)) begin
            irqMskD = pwdata[IRQ_W-1:0];
         // Read-only words ignore a write; unmapped words answer error
         end else if (!isAddr(paddr, ADDR_PAIR) &&
                      !isAddr(paddr, ADDR_STATUS)) begin
            errD = 1'b1;
         end
         errD = errD || cfgBad;
      end else if (access) begin
         if (isAddr(paddr, ADDR_MODE)) begin
            for (int i = 0; i < NOUT; i++) begin
               rdataD[4*i +: 3] = modeQ[i];
            end
         end else if (isAddr(paddr, ADDR_OUTBIT)) begin
            rdataD[NOUT-1:0] = outBitQ;
         end else if (isAddr(paddr, ADDR_GAP)) begin
            rdataD[15:0] = {gapCfgQ.delay, gapCfgQ.gap};
         end else if (isAddr(paddr, ADDR_PERIOD)) begin
            rdataD[7:0] = periodQ;
         end else if (isAddr(paddr, ADDR_PAIR)) begin
            rdataD[NUM_CONN-1:0] = pairResult;
         end else if (isAddr(paddr, ADDR_STATUS)) begin
            // Status word: lamp error, lamp status, then the outputs
            rdataD[NOUT+1:0] = {lampErr, lampStatus, test_signal_output};
         end else if (isAddr(paddr, ADDR_IRQST)) begin
            rdataD[IRQ_W-1:0] = irqStQ;
         end else if (isAddr(paddr, ADDR_IRQMSK)) begin
            rdataD[IRQ_W-1:0] = irqMskQ;
         end else begin
            errD = 1'b1;
         end
      end
      // Set wins over a clear in the same cycle
      if (lampErr) begin
         irqStD[IRQ_LAMP] = 1'b1;
      end
      if (cfgBad) begin
         irqStD[IRQ_CFG] = 1'b1;
      end
   end

   // Register bank
   // Reset leaves every output off and every interrupt masked
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NOUT; i++) begin
            modeQ[i] <= MODE_RST;
         end
         outBitQ <= '0;
         gapCfgQ <= '{gap: GAP_RST, delay: DELAY_RST};
         periodQ <= PERIOD_RST;
         irqStQ  <= '0;
         irqMskQ <= '0;
         rdataQ  <= 32'h0;
         readyQ  <= 1'b0;
         errQ    <= 1'b0;
      end else begin
         for (int i = 0; i < NOUT; i++) begin
            modeQ[i] <= modeD[i];
         end
         outBitQ <= outBitD;
         gapCfgQ <= gapCfgD;
         periodQ <= periodD;
         irqStQ  <= irqStD;
         irqMskQ <= irqMskD;
         rdataQ  <= rdataD;
         readyQ  <= readyD;
         errQ    <= errD;
      end
   end

   // Bus answer straight from its registers
   assign prdata  = rdataQ;
   assign pready  = readyQ;
   assign pslverr = errQ;

   // ****************************************************************
   // Long-gap timebase: 5 ms tick and period counter
   // ****************************************************************
   // One period counter is shared, since period is global to all
   // long-gap outputs; period 0 leaves the output held active.
   logic [31:0] tickCntQ, tickCntD;
   logic [7:0]  stepQ, stepD;
   logic        tick;

   always_comb begin
      tick     = (tickCntQ == 32'(STEP_CYC - 1));
      tickCntD = tick ? 32'h0 : tickCntQ + 32'h1;
      stepD    = stepQ;
      if (tick) begin
         // A shorter period wraps at the next tick, not mid-step
         stepD = nextStep(stepQ, periodQ);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tickCntQ <= 32'h0;
         stepQ    <= 8'h0;
      end else begin
         tickCntQ <= tickCntD;
         stepQ    <= stepD;
      end
   end

   // ****************************************************************
   // Output drive and lamp status
   // ****************************************************************
   // Registered outputs: every mode change shows one cycle later
   logic [NOUT-1:0] outD;
   logic            lampD;
   logic            irqD;

   always_comb begin
      for (int i = 0; i < NOUT; i++) begin
         case (modeQ[i])
            MODE_ON:     outD[i] = 1'b1;
            MODE_OFF:    outD[i] = 1'b0;
            MODE_REMOTE,
            MODE_LAMP:   outD[i] = outBitQ[i];
            MODE_TEST:   outD[i] = testPulse;
            MODE_GAP:    outD[i] = (periodQ == 8'h0) ||
                                   (stepQ >= gapCfgQ.gap);
            default:     outD[i] = 1'b0;
         endcase
         // Force beats every mode, so the safe state needs no write
         if (forceInactive) begin
            outD[i] = 1'b0;
         end
      end
      // Status one only with current in lamp mode
      lampD = (modeQ[0] == MODE_LAMP) && !forceInactive && !lampErr &&
              lampCurrentOk && outBitQ[0];
      // Interrupt level from the next status, so it tracks the bit
      irqD  = |(irqStD & irqMskD);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         test_signal_output <= '0;
         lampStatus         <= 1'b0;
         irq                <= 1'b0;
      end else begin
         test_signal_output <= outD;
         lampStatus         <= lampD;
         irq                <= irqD;
      end
   end

   // ****************************************************************
   // Dual-channel evaluation per connector
   // ****************************************************************
   // One evaluator per connector; none of them ever raises an error
   for (genvar c = 0; c < NUM_CONN; c++) begin : gPair
      pair_eval uPair (
         .clk        (clk),
         .sys_rst    (sys_rst),
         .chanA      (pairChanA[c]),
         .chanB      (pairChanB[c]),
         .pairActive (pairResult[c])
      );
   end

endmodule

// ---- sim/tso_assertions.sv ----
// Port-level checks for the test/signal output control block
`timescale 1ns/10ps
module tso_assertions #(
   parameter int unsigned NUM_CONN = 4
) (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  sys_rst,
   // Inputs seen by the block
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  forceInactive,
   input wire logic                  lampCurrentOk,
   input wire logic [NUM_CONN-1:0]   pairChanA,
   input wire logic [NUM_CONN-1:0]   pairChanB,
   // Outputs of the block
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic [2*NUM_CONN-1:0] test_signal_output,
   input wire logic [NUM_CONN-1:0]   pairResult,
   input wire logic                  lampStatus
);
   // ************************************************
   // Port relations, single clock domain
   // ************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_take; psel && penable && !pready |=> pready; endproperty
   a_take: assert property (p_take)
      else $error("access not answered");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse)
      else $error("ready longer than one cycle");
   property p_idle; !psel |=> !pready; endproperty
   a_idle: assert property (p_idle)
      else $error("ready without a transfer");
   property p_slverr; pslverr |-> pready; endproperty
   a_slverr: assert property (p_slverr)
      else $error("error without ready");
   property p_force_out; forceInactive |=> test_signal_output == '0;
   endproperty
   a_force_out: assert property (p_force_out)
      else $error("output active while forced");
   property p_force_lamp; forceInactive |=> !lampStatus; endproperty
   a_force_lamp: assert property (p_force_lamp)
      else $error("lamp status set while forced");
   // Status needs current seen and output driven
   property p_lamp;
      lampStatus |-> $past(lampCurrentOk) && test_signal_output[0];
   endproperty
   a_lamp: assert property (p_lamp)
      else $error("lamp status without current");
   // Latency of one or two cycles is accepted for the pair result
   property p_pair;
      (pairResult & ~(($past(pairChanA) & $past(pairChanB)) |
         ($past(pairChanA, 2) & $past(pairChanB, 2)))) == '0;
   endproperty
   a_pair: assert property (p_pair)
      else $error("pair active without both channels");
   c_lamp: cover property ($rose(lampStatus));
   c_pair: cover property ($rose(pairResult[0]));
   c_err: cover property (pslverr);
endmodule

bind test_signal_output_control tso_assertions #(.NUM_CONN(NUM_CONN))
   tso_assertions_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .forceInactive(forceInactive),
   .lampCurrentOk(lampCurrentOk), .pairChanA(pairChanA),
   .pairChanB(pairChanB), .pready(pready), .pslverr(pslverr),
   .test_signal_output(test_signal_output), .pairResult(pairResult),
   .lampStatus(lampStatus));

// ---- sim/lamp_partner.sv ----
// Lamp, driver fault and controller model on the far side
`timescale 1ns/10ps
module lamp_partner (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Block side
   input  wire logic lampDrive,
   input  wire logic lampStatus,
   // Scenario knobs
   input  wire logic lampFitted,
   input  wire logic stuckFault,
   // Model outputs
   output logic      lampCurrentOk,
   output logic      lampStuckHigh,
   output logic      lampAlarm_q
);
   // ************************************************
   // Lamp and controller behaviour
   // ************************************************
   logic lampAlarm_d;
   // Current flows only while driven and a lamp is fitted
   assign lampCurrentOk = lampFitted & lampDrive;
   // A stuck driver shows high even when driven low
   assign lampStuckHigh = stuckFault & ~lampDrive;
   // Controller alarms when a driven lamp is not confirmed
   always_comb lampAlarm_d = lampDrive & ~lampStatus;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) lampAlarm_q <= 1'b0;
      else lampAlarm_q <= lampAlarm_d;
   end
endmodule

// ---- sim/test_signal_output_control_tb.sv ----
// Self-checking bench for the test/signal output control block
`timescale 1ns/10ps
module test_signal_output_control_tb;
   import tso_pkg::*;
   // ************************************************
   // Signals, tables and instances
   // ************************************************
   logic clk, sys_rst, psel, penable, pwrite, testPulse, forceInactive;
   logic lampFitted, stuckFault, lampCurrentOk, lampStuckHigh, lampAlarm;
   logic pready, pslverr, lampStatus, irq, err;
   logic [7:0]  paddr, tso;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  pairChanA, pairChanB, pairResult;
   int          n_errors, check_count, lows;
   int          cyc = 0;
   out_mode_t   ml[4] = '{MODE_ON, MODE_OFF, MODE_REMOTE, MODE_TEST};
   logic [7:0]  oexp[4] = '{8'hff, 8'h00, 8'ha5, 8'hff};
   logic [2:0]  pseq[7] = '{3'h0, 3'h4, 3'h7, 3'h2, 3'h6, 3'h0, 3'h7};
   test_signal_output_control #(.NUM_CONN(4), .STEP_CYC(4))
      test_signal_output_control_inst (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .testPulse(testPulse),
      .forceInactive(forceInactive), .lampCurrentOk(lampCurrentOk),
      .lampStuckHigh(lampStuckHigh), .pairChanA(pairChanA),
      .pairChanB(pairChanB), .test_signal_output(tso),
      .pairResult(pairResult), .lampStatus(lampStatus), .irq(irq));
   lamp_partner lamp_partner_inst (.clk(clk), .sys_rst(sys_rst),
      .lampDrive(tso[0]), .lampStatus(lampStatus),
      .lampFitted(lampFitted), .stuckFault(stuckFault),
      .lampCurrentOk(lampCurrentOk), .lampStuckHigh(lampStuckHigh),
      .lampAlarm_q(lampAlarm));
   always #5 clk = ~clk;
   // Hang guard; the sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One APB transfer; data and error taken at the edge ending it
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic ee);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Waits until pready is seen high; the bench timeout ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pslverr", {31'h0, ee}, {31'h0, err});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0, 1'b0);
      chk("rdata", e, rdat);
   endtask
   function automatic logic [31:0] allm(input out_mode_t m);
      allm = '0;
      for (int i = 0; i < 8; i++) allm[4*i +: 3] = m;
   endfunction
   // ************************************************
   // Test sequence
   // ************************************************
   initial begin
      {clk, psel, penable, pwrite, testPulse, forceInactive} = '0;
      {lampFitted, stuckFault, paddr, pwdata, pairChanA, pairChanB} = '0;
      {n_errors, check_count} = '0;
      sys_rst = 1'b1;
      tick(5);
      sys_rst <= 1'b0;
      rd(ADDR_MODE, 32'h11111111);
      rd(ADDR_GAP, 32'h2);
      rd(ADDR_PERIOD, 32'hff);
      acc(1'b0, 8'h20, 32'h0, 1'b1);
      acc(1'b1, ADDR_IRQMSK, 32'h3, 1'b0);
      acc(1'b1, ADDR_OUTBIT, 32'ha5, 1'b0);
      testPulse <= 1'b1;
      // Each fixed, remote and test mode on all eight outputs
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, ADDR_MODE, allm(ml[k]), 1'b0);
         tick(3);
         chk("outputs", {24'h0, oexp[k]}, {24'h0, tso});
      end
      acc(1'b1, ADDR_OUTBIT, 32'h0, 1'b0);
      tick(3);
      chk("test mode", 32'hff, {24'h0, tso});
      testPulse <= 1'b0;
      tick(3);
      chk("test pulse", 32'h0, {24'h0, tso});
      // Lamp mode on output 1 refused, its field kept
      acc(1'b1, ADDR_MODE, 32'h11111131, 1'b1);
      acc(1'b1, ADDR_MODE, 32'h71111141, 1'b1);
      rd(ADDR_MODE, 32'h11111141);
      chk("cfg irq", 32'h1, {31'h0, irq});
      rd(ADDR_IRQST, 32'h2);
      acc(1'b1, ADDR_IRQST, 32'h2, 1'b0);
      rd(ADDR_IRQST, 32'h0);
      lampFitted <= 1'b1;
      acc(1'b1, ADDR_OUTBIT, 32'h1, 1'b0);
      acc(1'b1, ADDR_MODE, 32'h11111113, 1'b0);
      tick(3);
      chk("lamp on", 32'h1, {31'h0, lampStatus});
      rd(ADDR_STATUS, 32'h101);
      forceInactive <= 1'b1;
      tick(3);
      chk("forced", 32'h0, {23'h0, lampStatus, tso});
      forceInactive <= 1'b0;
      lampFitted <= 1'b0;
      tick(5);
      chk("open lamp", 32'h3, {29'h0, lampStatus, irq, lampAlarm});
      rd(ADDR_IRQST, 32'h1);
      lampFitted <= 1'b1;
      acc(1'b1, ADDR_IRQST, 32'h1, 1'b0);
      acc(1'b1, ADDR_OUTBIT, 32'h0, 1'b0);
      stuckFault <= 1'b1;
      tick(5);
      rd(ADDR_IRQST, 32'h1);
      stuckFault <= 1'b0;
      acc(1'b1, ADDR_IRQST, 32'h1, 1'b0);
      acc(1'b1, ADDR_OUTBIT, 32'h1, 1'b0);
      acc(1'b1, ADDR_MODE, allm(MODE_REMOTE), 1'b0);
      tick(3);
      chk("remote lamp", 32'h0, {31'h0, lampStatus});
      // Gap settings at and beyond their limits
      acc(1'b1, ADDR_GAP, 32'h0001, 1'b1);
      acc(1'b1, ADDR_GAP, 32'h0303, 1'b1);
      acc(1'b1, ADDR_GAP, 32'h0103, 1'b0);
      acc(1'b1, ADDR_PERIOD, 32'h3, 1'b1);
      acc(1'b1, ADDR_PERIOD, 32'h6, 1'b0);
      acc(1'b1, ADDR_GAP, 32'h0106, 1'b1);
      rd(ADDR_GAP, 32'h0103);
      acc(1'b1, ADDR_MODE, allm(MODE_GAP), 1'b0);
      tick(30);
      lows = 0;
      repeat (24) begin
         @(negedge clk);
         lows += !tso[2];
      end
      chk("gap cycles", 32'hc, lows);
      // Pair sequence with a long discrepancy and a re-arm
      acc(1'b1, ADDR_IRQST, 32'h3, 1'b0);
      for (int k = 0; k < 7; k++) begin
         pairChanA <= {4{pseq[k][2]}};
         pairChanB <= {4{pseq[k][1]}};
         tick(40);
         chk("pair", {28'h0, {4{pseq[k][0]}}}, {28'h0, pairResult});
      end
      rd(ADDR_IRQST, 32'h0);
      stop_test();
   end
endmodule
